// file: hw/srs_pkg.sv
/*
 Constants for the supply reset supervisor: timing in its own units and
 the derived cycle counts at the 100 MHz reference clock.
 Assumes ref_clk at 100 MHz.
*/
package srs_pkg;
    localparam int unsigned CLK_MHZ = 100;
    // Operator input must stay low longer than this
    localparam int unsigned OP_PULSE_US = 25;
    // Delay from accepted press to reset
    localparam int unsigned OP_DELAY_US = 12;
    localparam int unsigned OP_PULSE_CYC = OP_PULSE_US * CLK_MHZ;
    localparam int unsigned OP_DELAY_CYC = OP_DELAY_US * CLK_MHZ;
    // Reset timeout, plain default
    localparam int unsigned TIMEOUT_MS_DEF = 200;
    localparam int unsigned TIMEOUT_CYC_DEF = TIMEOUT_MS_DEF * 1000 * CLK_MHZ;
    localparam int unsigned CNT_W = 32;
    localparam logic RESET_VAL_ACTIVE = 1'b1;
endpackage

// file: hw/srs_debounce.sv
/*
 Operator reset debouncer: qualifies a low level held long enough, then
 delays the press before reporting it.
 Assumes the input is synchronous to ref_clk.
*/
`timescale 1ns/1ns
module srs_debounce
    import srs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Operator input and qualified press
    input wire logic op_in_n,
    output logic press_q
);
    logic [CNT_W-1:0] low_cnt_q;
    localparam logic [CNT_W-1:0] ASSERT_AT = CNT_W'(OP_PULSE_CYC + OP_DELAY_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Count low time; any high level restarts, so short pulses vanish
    always_ff @(posedge ref_clk) begin
        if (rst || op_in_n) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != ASSERT_AT) begin
            low_cnt_q <= low_cnt_q + CNT_W'(1);
        end
    end

    // Press held while input stays low, cleared as soon as it rises
    always_ff @(posedge ref_clk) begin
        if (rst || op_in_n) begin
            press_q <= 1'b0;
        end else if (low_cnt_q == ASSERT_AT - CNT_W'(1)) begin
            press_q <= 1'b1;
        end
    end
endmodule

// file: hw/srs_top.sv
/*
 Supply reset supervisor sequencer: reset from supply comparator and
 debounced operator input, timeout hold-off, early supply warning.
 Assumes comparator levels arrive synchronous to ref_clk.
*/
`timescale 1ns/1ns
module srs_top
    import srs_pkg::*;
#(
    parameter bit RESET_ACTIVE_HIGH = 1'b0,
    parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYC_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Comparators, high while supply below threshold
    input wire logic supply_low,
    input wire logic warning_low,
    // Operator reset, active low, may be driven by another supervisor
    input wire logic operator_reset_in_n,
    // Outputs to the processor
    output logic cpu_reset_q,
    output logic early_supply_warning_n
);
    localparam logic [CNT_W-1:0] TMO = CNT_W'(TIMEOUT_CYC);
    localparam logic POL = RESET_ACTIVE_HIGH;

    typedef enum logic [1:0] {ST_HOLD, ST_TIMING, ST_RUN} srs_state_t;

    srs_state_t state_q;
    logic press;
    logic cond;
    logic [CNT_W-1:0] tmo_cnt_q;

    ////////////////////////////////////////////////////////////////////////
    srs_debounce u_deb (
        .ref_clk(ref_clk),
        .rst(rst),
        .op_in_n(operator_reset_in_n),
        .press_q(press)
    );

    // Either reset condition
    assign cond = supply_low | press;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer; a condition always wins over timeout expiry
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_HOLD;
        end else if (cond) begin
            state_q <= ST_HOLD;
        end else begin
            unique case (state_q)
                ST_HOLD: state_q <= ST_TIMING;
                ST_TIMING: begin
                    if (tmo_cnt_q >= TMO - CNT_W'(1)) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: state_q <= ST_RUN;
            endcase
        end
    end

    // Timeout counter, held clear so reassertion restarts it fully
    always_ff @(posedge ref_clk) begin
        if (rst || cond || state_q != ST_TIMING) begin
            tmo_cnt_q <= '0;
        end else begin
            tmo_cnt_q <= tmo_cnt_q + CNT_W'(1);
        end
    end

    // Reset output; asserted from one edge after a condition appears
    always_ff @(posedge ref_clk) begin
        if (rst || cond) begin
            cpu_reset_q <= POL;
        end else if (state_q == ST_TIMING && tmo_cnt_q >= TMO - CNT_W'(1)) begin
            cpu_reset_q <= ~POL;
        end else if (state_q != ST_RUN) begin
            cpu_reset_q <= POL;
        end
    end

    // Warning; hysteresis lives in the analog comparator
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            early_supply_warning_n <= 1'b0;
        end else begin
            early_supply_warning_n <= ~warning_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    logic rst_act;
    assign rst_act = (cpu_reset_q == POL);

    sequence supply_drop_s;
        $rose(supply_low);
    endsequence

    sequence released_s;
        !cond && state_q == ST_RUN;
    endsequence

    supply_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        supply_low |=> rst_act) else $error("reset not on supply low");
    drop_state_a: assert property (@(posedge ref_clk) disable iff (rst)
        supply_drop_s |=> state_q == ST_HOLD) else $error("no hold on drop");
    early_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_TIMING && tmo_cnt_q < TMO - CNT_W'(1)) |=> rst_act)
        else $error("reset released before timeout");
    release_run_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst_act) |-> $past(state_q) == ST_TIMING)
        else $error("release without timing");
    polarity_a: assert property (@(posedge ref_clk) disable iff (rst)
        released_s |=> (cpu_reset_q == ~POL) || $past(cond) == 1'b0 && cond)
        else $error("wrong idle polarity");
    short_press_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(!operator_reset_in_n) ##1 (!operator_reset_in_n)[*8] |-> !press)
        else $error("short press accepted");
    op_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        press |=> rst_act) else $error("reset not held by operator");
    warn_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
        warning_low |=> !early_supply_warning_n)
        else $error("warning not low");
    cnt_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        cond |=> tmo_cnt_q == '0) else $error("timeout not cleared");

    ////////////////////////////////////////////////////////////////////////
    // Checker helpers
    // Plain counters stand in for long repetitions, which would unroll
    // into thousands of states. They feed assertions only and drive no
    // output, so synthesis trims them. Both saturate rather than wrap,
    // so a very long quiet spell cannot alias a short one.

    // Cycles since the last reset condition was seen
    logic [CNT_W-1:0] clear_cnt_q;
    always_ff @(posedge ref_clk) begin
        if (rst || cond) begin
            clear_cnt_q <= '0;
        end else if (clear_cnt_q != '1) begin
            clear_cnt_q <= clear_cnt_q + CNT_W'(1);
        end
    end

    // Cycles the operator input has stayed low without a break
    logic [CNT_W-1:0] op_low_cnt_q;
    always_ff @(posedge ref_clk) begin
        if (rst || operator_reset_in_n) begin
            op_low_cnt_q <= '0;
        end else if (op_low_cnt_q != '1) begin
            op_low_cnt_q <= op_low_cnt_q + CNT_W'(1);
        end
    end

    // Sequencer steps and operator release, each one cycle long
    // Conditions are folded into the hold and timing steps so a late glitch is excluded
    sequence hold_exit_s;
        state_q == ST_HOLD && !cond;
    endsequence

    sequence timing_step_s;
        state_q == ST_TIMING && !cond;
    endsequence

    sequence op_release_s;
        operator_reset_in_n;
    endsequence

    // Held block reset drives both outputs to their safe levels
    reset_out_a: assert property (@(posedge ref_clk)
        rst |=> rst_act) else $error("reset not asserted in reset");
    warn_reset_a: assert property (@(posedge ref_clk)
        rst |=> !early_supply_warning_n) else $error("warning not low in reset");
    warn_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        !warning_low |=> early_supply_warning_n) else $error("warning stuck low");

    // Once every condition is gone the sequencer must move on
    // A stall here would keep the processor in reset for ever
    timing_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
        hold_exit_s |=> state_q == ST_TIMING) else $error("no timing after hold");
    run_stays_a: assert property (@(posedge ref_clk) disable iff (rst)
        released_s |=> state_q == ST_RUN && !rst_act) else $error("run state left");
    cnt_step_a: assert property (@(posedge ref_clk) disable iff (rst)
        timing_step_s |=> tmo_cnt_q == $past(tmo_cnt_q) + CNT_W'(1))
        else $error("timeout counter skipped");

    // Counter never runs past the timeout it guards
    cnt_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
        tmo_cnt_q <= TMO) else $error("timeout counter overran");

    // State and output agree: hold means reset, run means released
    hold_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_HOLD |-> rst_act) else $error("hold without reset");
    run_free_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_RUN |-> !rst_act) else $error("run with reset");

    // Release never sooner than a full timeout after the last condition
    full_timeout_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst_act) |-> clear_cnt_q > TMO) else $error("timeout cut short");
    press_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        op_release_s |=> !press) else $error("press outlived input");

    // Accepted press only once the input has qualified as held low
    press_qualify_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(press) |-> op_low_cnt_q > CNT_W'(OP_PULSE_CYC))
        else $error("press accepted too soon");
endmodule

// file: verification/srs_cpu_model.sv
/*
 Processor side model: counts early warnings taken as interrupts.
 Assumes the reset input is active low.
*/
`timescale 1ns/1ns
module srs_cpu_model (
    // Clock and pins
    input wire logic ref_clk,
    input wire logic cpu_reset_n,
    input wire logic early_supply_warning_n,
    output int nmi_count
);
    logic warn_q = 1'b1;
    int nmi_q = 0;
    assign nmi_count = nmi_q;
    // Edge taken, not level, so a long warning counts once; none while in reset
    always @(posedge ref_clk) begin
        warn_q <= early_supply_warning_n;
        if (warn_q && !early_supply_warning_n && cpu_reset_n) nmi_q <= nmi_q + 1;
    end
endmodule

// file: verification/supply_reset_supervisor_bench.sv
/*
 Self-checking bench for the supervisor sequencer, with a short timeout.
 Assumes inputs already synchronous to ref_clk.
*/
`timescale 1ns/1ns
module supply_reset_supervisor_bench;
    import srs_pkg::*;
    localparam int TO = 20;
    logic ref_clk = 0, rst = 1, sup = 0, wrn = 0, op_n = 1, rq, wn, rq_hi;
    int err_count = 0, check_count = 0, nmi, n;
    // Clock
    always #5 ref_clk = ~ref_clk;
    srs_top #(.TIMEOUT_CYC(TO)) uut (.ref_clk(ref_clk), .rst(rst), .supply_low(sup),
        .warning_low(wrn), .operator_reset_in_n(op_n), .cpu_reset_q(rq),
        .early_supply_warning_n(wn));
    srs_top #(.RESET_ACTIVE_HIGH(1'b1), .TIMEOUT_CYC(TO)) uut_hi (.ref_clk(ref_clk),
        .rst(rst), .supply_low(sup), .warning_low(wrn), .operator_reset_in_n(op_n),
        .cpu_reset_q(rq_hi), .early_supply_warning_n());
    srs_cpu_model cpu (.ref_clk(ref_clk), .cpu_reset_n(rq), .early_supply_warning_n(wn),
        .nmi_count(nmi));
    ////////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(string nm, logic e, logic s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
        end
    endtask
    task cyc(int k);
        repeat (k) @(negedge ref_clk);
    endtask
    // Bounded wait for release; a hang ends the run
    task rel(string nm);
        n = 0;
        while (rq !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk(nm, 1'b1, n >= TO && n <= TO + 3);
        if (n >= 100) tally_and_finish();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_supply;
        sup = 1;
        cyc(1);
        chk("reset_n", 1'b0, rq);
        chk("reset_hi", 1'b1, rq_hi);
        sup = 0;
        cyc(10);
        sup = 1;
        cyc(1);
        sup = 0;
        rel("supply_timeout");
        chk("release_hi", 1'b0, rq_hi);
        $display("supply test done");
    endtask
    // Drives the operator input as outside logic would
    task t_operator;
        op_n = 0;
        cyc(2000);
        op_n = 1;
        cyc(2);
        chk("short_press", 1'b1, rq);
        op_n = 0;
        cyc(3600);
        chk("early_press", 1'b1, rq);
        cyc(110);
        chk("press", 1'b0, rq);
        cyc(500);
        chk("held", 1'b0, rq);
        op_n = 1;
        rel("press_timeout");
        $display("operator test done");
    endtask
    task t_warning;
        wrn = 1;
        cyc(2);
        chk("warn_low", 1'b0, wn);
        chk("nmi", 1'b1, nmi == 1);
        wrn = 0;
        cyc(2);
        chk("warn_high", 1'b1, wn);
        $display("warning test done");
    endtask
    initial begin
        cyc(10);
        rst = 0;
        rel("startup");
        t_supply();
        t_operator();
        t_warning();
        tally_and_finish();
    end
endmodule
